// ===== dar_host.sv
// Host model that drives select and the serial clock and captures data
`timescale 1ns/100ps
`default_nettype none
module dar_host (
  // System clock used only to pace the link clock and the select timing
  input wire logic i_clock,
  // Data pins from the device
  input wire dar_pkg::dar_pins_t i_pins,
  // Serial pins to the device
  output logic o_select_n,
  output logic o_sclk
);
  logic [31:0] cap_a;
  logic [31:0] cap_b;
  logic [31:0] cap_r_a;
  logic oe_seen;
  logic line_a;
  logic line_b;

  // A floating line shows the inverse of the last driven bit
  assign line_a = i_pins.oe_a ? i_pins.out_a : ~i_pins.out_a;
  assign line_b = i_pins.oe_b ? i_pins.out_b : ~i_pins.out_b;

  initial begin
    o_select_n = 1'b1;
    o_sclk = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_clock);
  endtask : wait_clk

  // Link clock halves of 4 system clocks give 320 ns; it idles high
  task automatic frame(input int n_falls);
    cap_a = 32'h0000_0000;
    cap_b = 32'h0000_0000;
    cap_r_a = 32'h0000_0000;
    oe_seen = 1'b1;
    o_select_n = 1'b0;
    wait_clk(8);
    for (int j = 0; j < n_falls; j++) begin
      // Sampled as the clock falls, before the device shifts
      cap_a = {cap_a[30:0], line_a};
      cap_b = {cap_b[30:0], line_b};
      oe_seen = oe_seen & i_pins.oe_a & i_pins.oe_b;
      o_sclk = 1'b0;
      wait_clk(4);
      // Slow link clock lets the device shift first, so the next bit is taken before the rise
      cap_r_a = {cap_r_a[30:0], line_a};
      o_sclk = 1'b1;
      wait_clk(4);
    end
  endtask : frame

  // Quiet gap after release before any new select fall
  task automatic release_cs;
    o_select_n = 1'b1;
    wait_clk(10);
  endtask : release_cs
endmodule : dar_host
`default_nettype wire

// ===== dar_pkg.sv
// Package for the dual converter serial readout block
package dar_pkg;
  localparam int RES_BITS = 12;
  localparam logic [5:0] EDGE_LSB_OUT = 6'h0D;
  localparam logic [5:0] EDGE_TRACK = 6'h0D;
  localparam logic [5:0] EDGE_PD_LO = 6'h02;
  localparam logic [5:0] EDGE_PD_HI = 6'h0A;
  localparam logic [5:0] EDGE_SECOND = 6'h10;
  localparam logic [5:0] EDGE_END = 6'h20;
  localparam logic [5:0] EDGE_MAX = 6'h3F;

  typedef enum logic [1:0] {DAR_ACTIVE, DAR_PARTIAL, DAR_FULL} dar_power_t;

  typedef struct packed {
    logic [RES_BITS-1:0] ch_a;
    logic [RES_BITS-1:0] ch_b;
  } dar_sample_t;

  typedef struct packed {
    logic out_a;
    logic out_b;
    logic oe_a;
    logic oe_b;
  } dar_pins_t;
endpackage : dar_pkg

// ===== dar_readout.sv
// Device-side serial conversion and readout logic of a dual converter
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Conversion and shifting advance only on sampled serial clock edges.
// - Select falling holds, samples both inputs, starts and drives outputs.
// - After 13 falling edges tracking resumes at the next rising edge.
// - A 16-bit transfer ends with two zeros after the last result bit.
// - Select rising ends conversion and floats both data outputs.
// - With select held for 16 more clocks, B goes out on A and A on B.
// - In the chained read the line floats on falling edge 32 or select rise.
// - Select falling itself presents the first leading zero.
// - Each falling edge shifts a bit, the first giving a second zero.
// - The result follows the zeros, its last bit out on falling edge 13.
// - Select rising after edge 2 and before edge 10 aborts and powers down.
module dar_readout (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Serial pins from the host
  input wire logic i_select_n,
  input wire logic i_sclk,
  // Sampled analog values from the converter core
  input wire dar_pkg::dar_sample_t i_sample,
  // Serial data pins and status
  output var dar_pkg::dar_pins_t o_pins,
  output logic o_track,
  output var dar_pkg::dar_power_t o_power
);
  logic [1:0] cs_sync_reg;
  logic [1:0] ck_sync_reg;
  logic cs_prev_reg;
  logic ck_prev_reg;
  logic cs_n_s;
  logic ck_s;
  logic cs_fall;
  logic cs_rise;
  logic ck_fall;
  logic ck_rise;

  // Both pins cross two flops before any logic sees them
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cs_sync_reg <= 2'h3;
      // Serial clock idles high, so reset to that level avoids a false edge
      ck_sync_reg <= 2'h3;
      cs_prev_reg <= 1'b1;
      ck_prev_reg <= 1'b1;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], i_select_n};
      ck_sync_reg <= {ck_sync_reg[0], i_sclk};
      cs_prev_reg <= cs_sync_reg[1];
      ck_prev_reg <= ck_sync_reg[1];
    end
  end

  assign cs_n_s = cs_sync_reg[1];
  assign ck_s = ck_sync_reg[1];
  assign cs_fall = cs_prev_reg & ~cs_n_s;
  assign cs_rise = ~cs_prev_reg & cs_n_s;
  assign ck_fall = ck_prev_reg & ~ck_s & ~cs_n_s;
  assign ck_rise = ~ck_prev_reg & ck_s & ~cs_n_s;

  logic [5:0] edges_reg, edges_next;
  logic [15:0] shift_a_reg, shift_a_next;
  logic [15:0] shift_b_reg, shift_b_next;
  logic drive_reg, drive_next;
  logic track_reg, track_next;
  dar_pkg::dar_power_t power_reg, power_next;
  logic out_a_reg, out_a_next;
  logic out_b_reg, out_b_next;
  dar_pkg::dar_sample_t held_reg, held_next;

  // Two zeros, result MSB first, two trailing zeros
  function automatic logic [15:0] frame(input logic [11:0] v);
    frame = {2'b00, v, 2'b00};
  endfunction : frame

  always_comb begin
    edges_next = edges_reg;
    shift_a_next = shift_a_reg;
    shift_b_next = shift_b_reg;
    drive_next = drive_reg;
    track_next = track_reg;
    power_next = power_reg;
    out_a_next = out_a_reg;
    out_b_next = out_b_reg;
    held_next = held_reg;
    if (cs_fall) begin
      // Hold, sample and drive the first leading zero at once
      track_next = 1'b0;
      drive_next = 1'b1;
      edges_next = 6'h00;
      held_next = i_sample;
      // Frame bit 15 is already on the pin, so the register starts at bit 14
      shift_a_next = frame(i_sample.ch_a) << 1;
      shift_b_next = frame(i_sample.ch_b) << 1;
      out_a_next = 1'b0;
      out_b_next = 1'b0;
    end else if (cs_rise) begin
      drive_next = 1'b0;
      track_next = 1'b1;
      if (edges_reg >= dar_pkg::EDGE_PD_LO &&
          edges_reg < dar_pkg::EDGE_PD_HI) begin
        power_next = (power_reg == dar_pkg::DAR_ACTIVE) ?
                     dar_pkg::DAR_PARTIAL : dar_pkg::DAR_FULL;
      end else if (edges_reg < dar_pkg::EDGE_PD_LO) begin
        // Early rise is treated as a glitch: power state kept
        power_next = power_reg;
      end else begin
        power_next = dar_pkg::DAR_ACTIVE;
      end
    end else if (ck_fall) begin
      if (edges_reg != dar_pkg::EDGE_MAX) begin
        edges_next = edges_reg + 6'h01;
      end
      out_a_next = shift_a_reg[15];
      out_b_next = shift_b_reg[15];
      shift_a_next = {shift_a_reg[14:0], 1'b0};
      shift_b_next = {shift_b_reg[14:0], 1'b0};
      if (edges_reg + 6'h01 == dar_pkg::EDGE_SECOND - 6'h01) begin
        // Swap so that B follows on line A and A on line B
        // Held copy keeps the second frame tied to the select-fall sample
        shift_a_next = frame(held_reg.ch_b);
        shift_b_next = frame(held_reg.ch_a);
      end
      if (edges_reg + 6'h01 == dar_pkg::EDGE_END) begin
        drive_next = 1'b0;
      end
    end else if (ck_rise && edges_reg >= dar_pkg::EDGE_TRACK) begin
      track_next = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      edges_reg <= 6'h00;
      shift_a_reg <= 16'h0000;
      shift_b_reg <= 16'h0000;
      drive_reg <= 1'b0;
      track_reg <= 1'b1;
      power_reg <= dar_pkg::DAR_ACTIVE;
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
      held_reg <= 24'h00_0000;
    end else begin
      edges_reg <= edges_next;
      shift_a_reg <= shift_a_next;
      shift_b_reg <= shift_b_next;
      drive_reg <= drive_next;
      track_reg <= track_next;
      power_reg <= power_next;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
      held_reg <= held_next;
    end
  end

  // Pins come straight from flops so the host never sees a glitch
  always_comb begin
    o_pins.out_a = out_a_reg;
    o_pins.out_b = out_b_reg;
    o_pins.oe_a = drive_reg;
    o_pins.oe_b = drive_reg;
  end
  assign o_track = track_reg;
  assign o_power = power_reg;

  property p_float_high;
    @(posedge i_clock) disable iff (i_rst)
      cs_rise |=> !o_pins.oe_a && !o_pins.oe_b;
  endproperty
  a_float_high: assert property (p_float_high)
    else $error("outputs still driven after select rise");

  property p_drive_fall;
    @(posedge i_clock) disable iff (i_rst)
      cs_fall |=> o_pins.oe_a && !o_pins.out_a && !o_track;
  endproperty
  a_drive_fall: assert property (p_drive_fall)
    else $error("select fall did not hold and drive a zero");

  property p_end32;
    @(posedge i_clock) disable iff (i_rst)
      ck_fall && !cs_fall && edges_reg == 6'h1F |=> !o_pins.oe_a;
  endproperty
  a_end32: assert property (p_end32)
    else $error("line not floated at falling edge 32");

  property p_second_zero;
    @(posedge i_clock) disable iff (i_rst)
      ck_fall && !cs_rise && edges_reg == 6'h00 |=> !o_pins.out_a;
  endproperty
  a_second_zero: assert property (p_second_zero)
    else $error("second leading zero missing");

  property p_trail;
    @(posedge i_clock) disable iff (i_rst)
      ck_fall && !cs_rise && (edges_reg == 6'h0D || edges_reg == 6'h0E)
      |=> !o_pins.out_a && !o_pins.out_b;
  endproperty
  a_trail: assert property (p_trail)
    else $error("trailing zero missing");

  property p_pd;
    @(posedge i_clock) disable iff (i_rst)
      cs_rise && edges_reg >= 6'h02 && edges_reg < 6'h0A
      |=> o_power != dar_pkg::DAR_ACTIVE;
  endproperty
  a_pd: assert property (p_pd)
    else $error("abort window did not power down");

  property p_track;
    @(posedge i_clock) disable iff (i_rst)
      ck_rise && !cs_rise && !cs_fall && edges_reg >= 6'h0D |=> o_track;
  endproperty
  a_track: assert property (p_track)
    else $error("no return to track after edge 13");

  property p_hold_early;
    @(posedge i_clock) disable iff (i_rst)
      ck_rise && !cs_rise && !cs_fall && edges_reg < 6'h0D && !o_track
      |=> !o_track;
  endproperty
  a_hold_early: assert property (p_hold_early)
    else $error("tracking resumed too early");

  property p_idle;
    @(posedge i_clock) disable iff (i_rst)
      cs_n_s && $past(cs_n_s) |-> !o_pins.oe_b;
  endproperty
  a_idle: assert property (p_idle)
    else $error("output driven while select high");
endmodule : dar_readout

`default_nettype wire

// ===== dar_readout_test.sv
// Self-checking testbench of the dual converter serial readout
`timescale 1ns/100ps
`default_nettype none
module dar_readout_test;
  logic i_clock;
  logic i_rst;
  logic select_n;
  logic sclk;
  dar_pkg::dar_sample_t sample;
  dar_pkg::dar_pins_t pins;
  logic track;
  dar_pkg::dar_power_t power;
  int num_errors;
  int n_tests;

  dar_readout dut (.i_clock(i_clock), .i_rst(i_rst), .i_select_n(select_n),
    .i_sclk(sclk), .i_sample(sample), .o_pins(pins), .o_track(track),
    .o_power(power));
  dar_host host (.i_clock(i_clock), .i_pins(pins), .o_select_n(select_n),
    .o_sclk(sclk));

  always #20 i_clock = ~i_clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic t_single;
    sample = {12'hA5C, 12'h3B6};
    host.frame(16);
    check(host.oe_seen, 1'h1);
    check(track, 1'h1);
    check(host.cap_a[15:0], {2'h0, 12'hA5C, 2'h0});
    check(host.cap_b[15:0], {2'h0, 12'h3B6, 2'h0});
    check(host.cap_r_a[15:0], {1'h0, 12'hA5C, 3'h0});
    host.release_cs();
    check({pins.oe_a, pins.oe_b}, 2'h0);
  endtask : t_single

  task automatic t_hold;
    host.frame(12);
    check(track, 1'h0);
    host.release_cs();
    check(power, dar_pkg::DAR_ACTIVE);
  endtask : t_hold

  task automatic t_chain;
    sample = {12'h6E1, 12'h19F};
    fork
      host.frame(32);
      begin
        // Inputs move after the select fall; the held values must go out
        repeat (40) @(negedge i_clock);
        sample = {12'hC3C, 12'h5A5};
      end
    join
    check(host.cap_a, {2'h0, 12'h6E1, 4'h0, 12'h19F, 2'h0});
    check(host.cap_b, {2'h0, 12'h19F, 4'h0, 12'h6E1, 2'h0});
    // Select is still low here, so only the count can float the lines
    check({pins.oe_a, pins.oe_b}, 2'h0);
    host.release_cs();
  endtask : t_chain

  task automatic t_power;
    host.frame(1);
    host.release_cs();
    check(power, dar_pkg::DAR_ACTIVE);
    host.frame(5);
    host.release_cs();
    check(power, dar_pkg::DAR_PARTIAL);
    check({pins.oe_a, pins.oe_b}, 2'h0);
    host.frame(9);
    host.release_cs();
    check(power, dar_pkg::DAR_FULL);
    host.frame(16);
    host.release_cs();
    check(power, dar_pkg::DAR_ACTIVE);
  endtask : t_power

  initial begin
    i_clock = 1'b0;
    i_rst = 1'b1;
    sample = 24'h00_0000;
    num_errors = 0;
    n_tests = 0;
    repeat (3) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clock);
    check(pins, 4'h0);
    check(track, 1'h1);
    check(power, dar_pkg::DAR_ACTIVE);
    t_single();
    t_hold();
    t_chain();
    t_power();
    end_sim();
  end

  // Hang guard well beyond the whole sequence
  initial begin
    #2000000;
    num_errors++;
    end_sim();
  end
endmodule : dar_readout_test
`default_nettype wire
